// [include/stl_pkg.sv]
// Constants, field positions and carrier types for the test-source and
// load-next-event select block.
// Assumes a single 40 MHz system clock and a board-relative byte offset.
package stl_pkg;

  // Clock and rates.
  localparam int CLK_MHZ = 40;
  localparam int CLK_NS = 25;
  localparam int TEST_PULSE_MHZ = 25;
  localparam int TEST_PULSE_NS = 40;
  localparam int INT_LNE_MHZ = 10;
  localparam int INT_LNE_DIV = CLK_MHZ / INT_LNE_MHZ;
  localparam int INIT_US = 1;
  localparam int INIT_CYCLES = INIT_US * 1000 / CLK_NS;

  // Register offsets (board-relative byte addresses).
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CNT_EN = 12'h004;
  localparam logic [11:0] OFS_INMODE = 12'h008;
  localparam logic [11:0] OFS_PRESC = 12'h00c;
  localparam logic [11:0] OFS_SOFT_LNE = 12'h010;
  localparam logic [11:0] OFS_KEY_PULSE = 12'h068;
  localparam logic [11:0] OFS_FIFO_LO = 12'h100;
  localparam logic [11:0] OFS_FIFO_HI = 12'h1fc;

  // Control register: writing a one to bit n sets a flag, to n+8 clears it.
  localparam int CB_FIFO_TEST = 1;
  localparam int CB_TEST = 2;
  localparam int CB_PULSER = 3;
  localparam int CB_REF = 4;
  localparam int CB_LNE_EXT = 5;
  localparam int CB_LNE_INT = 6;
  localparam int CB_LNE_PRESC = 7;
  localparam int CB_CLR_OFS = 8;

  // Reset values, and the test input mode.
  localparam logic [31:0] CNT_EN_RST = 32'hffffffff;
  localparam logic [1:0] INMODE_RST = 2'h0;
  localparam logic [1:0] INMODE_TEST = 2'h3;

  // Address modifiers.
  localparam logic [5:0] AM_A16_SUP = 6'h2d;
  localparam logic [5:0] AM_A16_USR = 6'h29;
  localparam logic [5:0] AM_A24_SUP_BLT = 6'h3f;
  localparam logic [5:0] AM_A24_USR_BLT = 6'h3b;
  localparam logic [5:0] AM_A24_SUP = 6'h3d;
  localparam logic [5:0] AM_A24_USR = 6'h39;
  localparam logic [5:0] AM_A32_SUP_BLT = 6'h0f;
  localparam logic [5:0] AM_A32_USR_BLT = 6'h0b;
  localparam logic [5:0] AM_A32_SUP = 6'h0d;
  localparam logic [5:0] AM_A32_USR = 6'h09;

  // Indicators: bit 0 ready, bit 1 power.
  localparam logic [7:0] LED_INIT = 8'hfe;
  localparam logic [7:0] LED_RUN = 8'h03;

  typedef struct packed {
    logic fifo_test;
    logic test_mode;
    logic pulser25;
    logic ref_en;
    logic lne_ext;
    logic lne_int;
    logic lne_presc;
  } stl_ctrl_t;

  localparam stl_ctrl_t CTRL_RST = 7'h00;

  typedef struct packed {
    logic strobe;
    logic we;
    logic [5:0] am;
    logic [11:0] addr;
    logic [31:0] wdata;
  } stl_bus_req_t;

endpackage

// [src/stl_sync.sv]
// Three-stage input synchroniser with agreement filter and rise pulse.
// Assumes an input from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module stl_sync (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic prev_reg;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // The level only moves once the last two stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
      prev_reg <= level_o;
    end
  end

  assign rise_o = level_o & ~prev_reg;
endmodule
`default_nettype wire

// [src/stl_am_check.sv]
// Address modifier acceptance against the enabled addressing spaces.
// Assumes the space enables are stable straps.
`timescale 1ns/1ps
`default_nettype none
module stl_am_check (
  input wire logic [5:0] am_i,
  input wire logic en_a16_i,
  input wire logic en_a24_i,
  input wire logic en_a32_i,
  output logic accept_o
);
  always_comb begin
    unique case (am_i)
      stl_pkg::AM_A16_SUP, stl_pkg::AM_A16_USR: accept_o = en_a16_i;
      stl_pkg::AM_A24_SUP_BLT,
      stl_pkg::AM_A24_USR_BLT: accept_o = en_a24_i;
      stl_pkg::AM_A24_SUP, stl_pkg::AM_A24_USR: accept_o = en_a24_i;
      stl_pkg::AM_A32_SUP_BLT,
      stl_pkg::AM_A32_USR_BLT: accept_o = en_a32_i;
      stl_pkg::AM_A32_SUP, stl_pkg::AM_A32_USR: accept_o = en_a32_i;
      default: accept_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [src/stl_select.sv]
// Test source, reference pulser and load-next-event source selection.
// Assumes bus strobes arrive one cycle long from a front end on clk_sys_i,
// and that the counters, the FIFO and the indicators sit outside.
`timescale 1ns/1ps
`default_nettype none
module stl_select #(
  parameter int NCH = 32,
  parameter int PRESC_W = 28
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire stl_pkg::stl_bus_req_t bus_i,
  output logic bus_ack_o,
  output logic [31:0] bus_rdata_o,
  input wire logic en_a16_i,
  input wire logic en_a24_i,
  input wire logic en_a32_i,
  input wire logic [NCH-1:0] chan_in_i,
  input wire logic [3:0] ctl_in_i,
  output logic [NCH-1:0] count_o,
  output logic load_next_event_o,
  output logic [1:0] user_bits_o,
  output logic fifo_wr_o,
  output logic [31:0] fifo_wdata_o,
  output logic fifo_test_o,
  output logic [7:0] led_o
);
  if (NCH < 1 || NCH > 32 || PRESC_W < 1 || PRESC_W > 32) begin : g_chk
    $error("stl_select: NCH must be 1..32 and PRESC_W 1..32");
  end
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  stl_pkg::stl_ctrl_t ctrl_reg;
  logic [31:0] cnt_en_reg;
  logic [1:0] inmode_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic [PRESC_W-1:0] presc_cnt_reg;
  logic [2:0] strap_reg;
  logic [15:0] init_cnt_reg;
  logic init_done_reg;
  logic [5:0] acc_reg;
  logic gen_pulse_reg;
  logic single_reg;
  logic [1:0] div_reg;
  logic int_pulse;
  logic am_ok;
  logic acc_wr;
  logic wr_ctrl;
  logic wr_key;
  logic wr_soft;
  logic in_fifo_win;
  logic [NCH-1:0] chan_rise;
  logic [3:0] ctl_lvl;
  logic [3:0] ctl_rise;
  logic ext_lne;
  logic ch1_lne;
  logic hw_direct;
  logic presc_src;
  logic presc_out;
  logic test_pulse;
  logic [NCH-1:0] count_next;
  logic [6:0] acc_sum;

  // Space enables are jumpers: caught while reset is held, then frozen.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strap_reg <= {en_a32_i, en_a24_i, en_a16_i};
    end
  end

  stl_am_check u_am (
    .am_i(bus_i.am),
    .en_a16_i(strap_reg[0]),
    .en_a24_i(strap_reg[1]),
    .en_a32_i(strap_reg[2]),
    .accept_o(am_ok)
  );

  // A refused modifier simply gets no acknowledge, as on a real backplane.
  assign acc_wr = bus_i.strobe & am_ok & bus_i.we;
  assign wr_ctrl = acc_wr & (bus_i.addr == stl_pkg::OFS_CTRL);
  assign wr_key = acc_wr & (bus_i.addr == stl_pkg::OFS_KEY_PULSE);
  assign wr_soft = acc_wr & (bus_i.addr == stl_pkg::OFS_SOFT_LNE);
  assign in_fifo_win = (bus_i.addr >= stl_pkg::OFS_FIFO_LO) &&
                       (bus_i.addr <= stl_pkg::OFS_FIFO_HI) &&
                       (bus_i.addr[1:0] == 2'h0);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 32'h00000000;
    end else begin
      bus_ack_o <= bus_i.strobe & am_ok;
      bus_rdata_o <= 32'h00000000;
      if (bus_i.strobe & am_ok & ~bus_i.we) begin
        unique case (bus_i.addr)
          stl_pkg::OFS_CTRL: begin
            bus_rdata_o[stl_pkg::CB_FIFO_TEST] <= ctrl_reg.fifo_test;
            bus_rdata_o[stl_pkg::CB_TEST] <= ctrl_reg.test_mode;
            bus_rdata_o[stl_pkg::CB_PULSER] <= ctrl_reg.pulser25;
            bus_rdata_o[stl_pkg::CB_REF] <= ctrl_reg.ref_en;
            bus_rdata_o[stl_pkg::CB_LNE_EXT] <= ctrl_reg.lne_ext;
            bus_rdata_o[stl_pkg::CB_LNE_INT] <= ctrl_reg.lne_int;
            bus_rdata_o[stl_pkg::CB_LNE_PRESC] <= ctrl_reg.lne_presc;
          end
          stl_pkg::OFS_CNT_EN: bus_rdata_o <= cnt_en_reg;
          stl_pkg::OFS_INMODE: bus_rdata_o[1:0] <= inmode_reg;
          stl_pkg::OFS_PRESC: bus_rdata_o[PRESC_W-1:0] <= presc_reg;
          default: bus_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control flags: set on bit n, cleared on bit n+8; set wins if both.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_reg <= stl_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      if (bus_i.wdata[stl_pkg::CB_FIFO_TEST]) begin
        ctrl_reg.fifo_test <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_FIFO_TEST +
                               stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.fifo_test <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_TEST]) begin
        ctrl_reg.test_mode <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_TEST+stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.test_mode <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_PULSER]) begin
        ctrl_reg.pulser25 <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_PULSER+stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.pulser25 <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_REF]) begin
        ctrl_reg.ref_en <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_REF+stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.ref_en <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_LNE_EXT]) begin
        ctrl_reg.lne_ext <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_LNE_EXT+stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.lne_ext <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_LNE_INT]) begin
        ctrl_reg.lne_int <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_LNE_INT+stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.lne_int <= 1'b0;
      end
      if (bus_i.wdata[stl_pkg::CB_LNE_PRESC]) begin
        ctrl_reg.lne_presc <= 1'b1;
      end else if (bus_i.wdata[stl_pkg::CB_LNE_PRESC +
                               stl_pkg::CB_CLR_OFS]) begin
        ctrl_reg.lne_presc <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_en_reg <= stl_pkg::CNT_EN_RST;
      inmode_reg <= stl_pkg::INMODE_RST;
      presc_reg <= '0;
    end else if (acc_wr) begin
      if (bus_i.addr == stl_pkg::OFS_CNT_EN) begin
        cnt_en_reg <= bus_i.wdata;
      end
      if (bus_i.addr == stl_pkg::OFS_INMODE) begin
        inmode_reg <= bus_i.wdata[1:0];
      end
      if (bus_i.addr == stl_pkg::OFS_PRESC) begin
        presc_reg <= bus_i.wdata[PRESC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fifo_wr_o <= 1'b0;
      fifo_wdata_o <= 32'h00000000;
    end else begin
      fifo_wr_o <= acc_wr & in_fifo_win & ctrl_reg.fifo_test;
      if (acc_wr & in_fifo_win & ctrl_reg.fifo_test) begin
        fifo_wdata_o <= bus_i.wdata;
      end
    end
  end
  assign fifo_test_o = ctrl_reg.fifo_test;

  // Indicator self-test window after reset.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_cnt_reg <= 16'h0000;
      init_done_reg <= 1'b0;
      led_o <= stl_pkg::LED_INIT;
    end else begin
      if (init_cnt_reg == 16'(stl_pkg::INIT_CYCLES - 1)) begin
        init_done_reg <= 1'b1;
      end else begin
        init_cnt_reg <= init_cnt_reg + 16'h0001;
      end
      led_o <= init_done_reg ? stl_pkg::LED_RUN : stl_pkg::LED_INIT;
    end
  end

  // 25 MHz from 40 MHz cannot be a clean divide, so a phase accumulator
  // spreads 25 pulses over every 40 cycles; the average rate is exact.
  assign acc_sum = {1'b0, acc_reg} + 7'(stl_pkg::TEST_PULSE_MHZ);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_reg <= 6'h00;
      gen_pulse_reg <= 1'b0;
      div_reg <= 2'h0;
    end else begin
      if (acc_sum >= 7'(stl_pkg::CLK_MHZ)) begin
        acc_reg <= 6'(acc_sum - 7'(stl_pkg::CLK_MHZ));
        gen_pulse_reg <= 1'b1;
      end else begin
        acc_reg <= acc_sum[5:0];
        gen_pulse_reg <= 1'b0;
      end
      if (div_reg == 2'(stl_pkg::INT_LNE_DIV - 1)) begin
        div_reg <= 2'h0;
      end else begin
        div_reg <= div_reg + 2'h1;
      end
    end
  end
  assign int_pulse = (div_reg == 2'h0);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      single_reg <= 1'b0;
    end else begin
      single_reg <= wr_key & ctrl_reg.test_mode;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    stl_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(chan_in_i[g]),
      .level_o(),
      .rise_o(chan_rise[g])
    );
  end
  for (genvar c = 0; c < 4; c++) begin : g_ctl
    stl_sync u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(ctl_in_i[c]),
      .level_o(ctl_lvl[c]),
      .rise_o(ctl_rise[c])
    );
  end

  assign ext_lne = ctl_rise[0] &
                   (inmode_reg != stl_pkg::INMODE_TEST);

  always_comb begin
    hw_direct = 1'b0;
    presc_src = 1'b0;
    ch1_lne = 1'b0;
    unique case ({ctrl_reg.lne_ext, ctrl_reg.lne_int, ctrl_reg.lne_presc})
      3'h0, 3'h2: hw_direct = 1'b0;
      3'h1: begin
        presc_src = chan_rise[0];
        ch1_lne = 1'b1;
      end
      3'h3, 3'h7: presc_src = int_pulse;
      3'h4, 3'h6: hw_direct = ext_lne;
      3'h5: presc_src = ext_lne;
    endcase
  end

  // A factor of zero behaves as one, so the divider never locks up.
  assign presc_out = presc_src & (presc_cnt_reg + 1'b1 >= presc_reg);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      presc_cnt_reg <= '0;
    end else if (presc_src) begin
      presc_cnt_reg <= presc_out ? '0 : presc_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      load_next_event_o <= 1'b0;
      user_bits_o <= 2'h0;
    end else begin
      load_next_event_o <= wr_soft | hw_direct | presc_out;
      if (ext_lne) begin
        user_bits_o <= ctl_lvl[2:1];
      end
    end
  end

  assign test_pulse = single_reg | (ctrl_reg.pulser25 & gen_pulse_reg);
  always_comb begin
    count_next = '0;
    for (int i = 0; i < NCH; i++) begin
      if (ctrl_reg.test_mode) begin
        count_next[i] = test_pulse;
      end else if (i == 0 && ctrl_reg.ref_en) begin
        count_next[i] = gen_pulse_reg;
      end else if (i == 0 && ch1_lne) begin
        count_next[i] = 1'b0;
      end else begin
        count_next[i] = chan_rise[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else begin
      count_o <= count_next & cnt_en_reg[NCH-1:0];
    end
  end

  a_led_init: assert property (!$past(init_done_reg)
    |-> led_o == stl_pkg::LED_INIT)
    else $error("indicators wrong during init");
  a_key_pulse: assert property (wr_key && ctrl_reg.test_mode
    |-> ##2 count_o == $past(cnt_en_reg[NCH-1:0]))
    else $error("single pulse missing");
  a_key_blocked: assert property (wr_key && !ctrl_reg.test_mode
    |=> !single_reg)
    else $error("single pulse without test mode");
  a_count_gate: assert property (
    (count_o & ~$past(cnt_en_reg[NCH-1:0])) == '0)
    else $error("disabled channel counted");
  a_pulser_all: assert property (
    $past(ctrl_reg.test_mode && ctrl_reg.pulser25 && gen_pulse_reg)
    |-> count_o == $past(cnt_en_reg[NCH-1:0]))
    else $error("test pulser missed a channel");
  a_ref_ch1: assert property (
    $past(ctrl_reg.ref_en && !ctrl_reg.test_mode)
    |-> count_o[0] == $past(gen_pulse_reg & cnt_en_reg[0]))
    else $error("channel one not on reference");
  a_lne_soft: assert property (wr_soft |=> load_next_event_o)
    else $error("software load pulse lost");
  a_ch1_lne: assert property (
    ch1_lne && !ctrl_reg.ref_en && !ctrl_reg.test_mode
    |=> !count_o[0])
    else $error("channel one counted while load source");
  a_fifo_push: assert property (
    acc_wr && in_fifo_win && ctrl_reg.fifo_test
    |=> fifo_wr_o && fifo_wdata_o == $past(bus_i.wdata))
    else $error("FIFO test write not pushed");
  a_fifo_block: assert property (!$past(ctrl_reg.fifo_test)
    |-> !fifo_wr_o)
    else $error("FIFO pushed outside test mode");
  a_fifo_leave: assert property (wr_ctrl
    && bus_i.wdata[stl_pkg::CB_FIFO_TEST+stl_pkg::CB_CLR_OFS]
    && !bus_i.wdata[stl_pkg::CB_FIFO_TEST] |=> !fifo_test_o)
    else $error("FIFO test mode not left");
  a_am_reject: assert property (!(bus_i.strobe && am_ok)
    |=> !bus_ack_o)
    else $error("refused modifier acknowledged");
endmodule
`default_nettype wire

// [sim/stl_cpu_model.sv]
// Bus master model that issues register accesses to the select block.
// Assumes its tasks are entered just after a rising edge of clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module stl_cpu_model (
  input wire logic clk_sys_i,
  output var stl_pkg::stl_bus_req_t bus_o
);
  initial bus_o = '0;

  // The strobe stays up across calls, so back to back accesses never drop
  // and raise it within one time step.
  task automatic acc(input logic we, input logic [5:0] am,
                     input logic [11:0] a, input logic [31:0] d);
    bus_o = {1'b1, we, am, a, d};
    @(posedge clk_sys_i);
    #2;
  endtask

  // Released lines show the inverse of their last value, never a copy.
  task automatic idle(input int n);
    bus_o = {1'b0, ~bus_o[50:0]};
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
endmodule
`default_nettype wire

// [sim/scaler_test_and_lne_select_tb.sv]
// Self-checking bench for the test-source and load-next-event select block.
// Assumes the bus master model in stl_cpu_model and assertions in the design.
`timescale 1ns/1ps
`default_nettype none
module scaler_test_and_lne_select_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_a16 = 1'b1;
  logic en_a24 = 1'b1;
  logic en_a32 = 1'b0;
  logic [31:0] chan_in = 32'h0;
  logic [3:0] ctl_in = 4'h0;
  logic cnt_watch = 1'b0;
  logic bus_ack, lne, fifo_wr, fifo_test;
  logic [31:0] rdata, count, fifo_wd, ce, d;
  logic [1:0] ubits, ub;
  logic [2:0] sp;
  logic [7:0] led;
  logic [32:0] m;
  logic [32:0] q_ack[$];
  logic [31:0] q_fifo[$];
  logic [31:0] q_cnt[$];
  stl_pkg::stl_bus_req_t bus;
  int n_fail = 0;
  int checks_done = 0;
  int n_ev[4];
  integer seed = 93;
  logic [5:0] ams [10] = '{stl_pkg::AM_A16_SUP, stl_pkg::AM_A16_USR,
    stl_pkg::AM_A24_SUP_BLT, stl_pkg::AM_A24_USR_BLT, stl_pkg::AM_A24_SUP,
    stl_pkg::AM_A24_USR, stl_pkg::AM_A32_SUP_BLT, stl_pkg::AM_A32_USR_BLT,
    stl_pkg::AM_A32_SUP, stl_pkg::AM_A32_USR};

  stl_select uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .bus_ack_o(bus_ack),
    .bus_rdata_o(rdata), .en_a16_i(en_a16), .en_a24_i(en_a24),
    .en_a32_i(en_a32), .chan_in_i(chan_in), .ctl_in_i(ctl_in),
    .count_o(count), .load_next_event_o(lne), .user_bits_o(ubits),
    .fifo_wr_o(fifo_wr), .fifo_wdata_o(fifo_wd), .fifo_test_o(fifo_test),
    .led_o(led)
  );
  stl_cpu_model cpu (.clk_sys_i(clk_sys_i), .bus_o(bus));

  always #12.5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic ok, input string s);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR at %0t ns: %s", $time, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    cpu.acc(1'b1, stl_pkg::AM_A24_SUP, a, v);
    q_ack.push_back(33'h0);
    cpu.idle(1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    cpu.acc(1'b0, stl_pkg::AM_A24_USR, a, 32'h0);
    q_ack.push_back({1'b1, v});
    cpu.idle(1);
  endtask

  task automatic ctl(input logic [31:0] v);
    wr(stl_pkg::OFS_CTRL, v);
  endtask

  task automatic win(input int n);
    n_ev = '{default: 0};
    cpu.idle(n);
  endtask

  function automatic logic near(input int v, input int x);
    return v >= x - 2 && v <= x + 2;
  endfunction

  // Eight pulses, 4 cycles wide, on the external load input and channel one.
  task automatic drive();
    repeat (8) begin
      {ctl_in[3], ub} = 3'($random(seed));
      ctl_in[2:1] = ub;
      @(posedge clk_sys_i);
      #2 ctl_in[0] = 1'b1;
      chan_in[0] = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #2 ctl_in[0] = 1'b0;
      chan_in[0] = 1'b0;
      repeat (11) @(posedge clk_sys_i);
      #2;
    end
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys_i);
      #2 chan_in[0] = ~chan_in[0];
    end
  endtask

  // Bit 0 external, bit 1 internal, bit 2 prescaler; prescale factor is 2.
  task automatic lne_run(input int c);
    int x[8] = '{0, 8, 0, 8, 4, 4, 16, 16};
    ctl(32'(((~c & 7) << 13) | (c << 5)));
    fork
      win(128);
      drive();
    join
    chk(near(n_ev[0], x[c]), "load pulse count");
    chk(c == 4 ? n_ev[1] == 0 : near(n_ev[1], 8), "channel one");
    if (c[0]) chk(ubits === ub, "user bits");
    if (c < 6) begin
      n_ev[0] = 0;
      wr(stl_pkg::OFS_SOFT_LNE, 32'h0);
      cpu.idle(4);
      chk(n_ev[0] == 1, "software load pulse");
    end
  endtask

  always @(negedge clk_sys_i) begin
    if (bus_ack === 1'b1) begin
      if (q_ack.size() == 0) chk(1'b0, "ack to refused access");
      else begin
        m = q_ack.pop_front();
        if (m[32]) chk(rdata === m[31:0], "read data");
      end
    end
    if (fifo_wr === 1'b1) begin
      if (q_fifo.size() == 0) chk(1'b0, "stray fifo push");
      else chk(fifo_wd === q_fifo.pop_front(), "fifo data");
    end
    if (cnt_watch && count !== 32'h0) begin
      if (q_cnt.size() == 0) chk(1'b0, "stray count");
      else chk(count === q_cnt.pop_front(), "pulse pattern");
    end
    n_ev[0] += int'(lne === 1'b1);
    n_ev[1] += int'(count[0] === 1'b1);
    n_ev[2] += int'(count[1] === 1'b1);
    n_ev[3] += int'(count !== 32'h0 && count !== 32'hffffffff);
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    #2 chk(led === stl_pkg::LED_INIT, "indicators in reset");
    rst_i = 1'b0;
    cpu.acc(1'b0, stl_pkg::AM_A32_SUP, stl_pkg::OFS_CNT_EN, 32'h0);
    cpu.idle(3);
    rd(stl_pkg::OFS_CNT_EN, stl_pkg::CNT_EN_RST);
    chk(led === stl_pkg::LED_INIT, "indicators in self-test");
    repeat (stl_pkg::INIT_CYCLES) @(posedge clk_sys_i);
    #2 chk(led === stl_pkg::LED_RUN, "indicators after init");
    $display("done: self-test and straps");
    // First a random strap set, then every space on for the later tests.
    for (int k = 0; k < 2; k++) begin
      rst_i = 1'b1;
      sp = (k == 0) ? 3'($random(seed)) : 3'h7;
      {en_a32, en_a24, en_a16} = sp;
      repeat (2) @(posedge clk_sys_i);
      #2 rst_i = 1'b0;
      foreach (ams[i]) begin
        cpu.acc(1'b0, ams[i], stl_pkg::OFS_CNT_EN, 32'h0);
        if (sp[i < 2 ? 0 : (i < 6 ? 1 : 2)]) begin
          q_ack.push_back({1'b1, stl_pkg::CNT_EN_RST});
        end
      end
      cpu.acc(1'b0, 6'h3e, stl_pkg::OFS_CNT_EN, 32'h0);
      cpu.idle(3);
    end
    rd(12'h020, 32'h0);
    ce = $random(seed);
    wr(stl_pkg::OFS_CNT_EN, ce);
    rd(stl_pkg::OFS_CNT_EN, ce);
    $display("done: address modifiers");
    ctl(32'h4);
    chan_in = $random(seed);
    cnt_watch = 1'b1;
    wr(stl_pkg::OFS_KEY_PULSE, 32'h0);
    q_cnt.push_back(ce);
    cpu.idle(8);
    chan_in = 32'h0;
    cpu.idle(8);
    ctl(32'h400);
    wr(stl_pkg::OFS_KEY_PULSE, 32'h0);
    cpu.idle(8);
    cnt_watch = 1'b0;
    $display("done: single pulse");
    wr(stl_pkg::OFS_CNT_EN, 32'hffffffff);
    ctl(32'h8);
    win(80);
    chk(n_ev[2] == 0, "pulser without test mode");
    ctl(32'h4);
    win(400);
    chk(near(n_ev[2], 250), "pulser rate");
    chk(n_ev[3] == 0, "pulser on all channels");
    ctl(32'h10);
    win(400);
    chk(n_ev[1] == n_ev[2], "test before reference");
    ctl(32'hc00);
    fork
      win(400);
      toggle(50);
    join
    chk(near(n_ev[1], 250), "reference rate");
    chk(n_ev[2] == 0, "reference on channel one only");
    ctl(32'h1000);
    $display("done: pulsers");
    wr(stl_pkg::OFS_PRESC, 32'h2);
    for (int c = 0; c < 8; c++) lne_run(c);
    wr(stl_pkg::OFS_INMODE, 32'(stl_pkg::INMODE_TEST));
    ctl(32'hc020);
    fork
      win(128);
      drive();
    join
    chk(n_ev[0] == 0, "external load in test input mode");
    wr(stl_pkg::OFS_INMODE, 32'h0);
    ctl(32'he000);
    $display("done: load source");
    wr(stl_pkg::OFS_FIFO_LO, 32'h0);
    ctl(32'h2);
    rd(stl_pkg::OFS_CTRL, 32'h2);
    chk(fifo_test === 1'b1, "fifo test entered");
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      cpu.acc(1'b1, stl_pkg::AM_A32_USR, 12'h1fc - 12'(i * 'h7c), d);
      q_ack.push_back(33'h0);
      q_fifo.push_back(d);
    end
    cpu.acc(1'b1, stl_pkg::AM_A32_USR, 12'h200, 32'h5);
    q_ack.push_back(33'h0);
    cpu.idle(3);
    ctl(32'h200);
    cpu.idle(1);
    chk(fifo_test === 1'b0, "fifo test left");
    wr(stl_pkg::OFS_FIFO_HI, 32'h0);
    cpu.idle(4);
    chk(q_ack.size() + q_fifo.size() + q_cnt.size() == 0, "results missing");
    $display("done: fifo test");
    test_done();
  end

  initial begin
    #(20000 * 25);
    n_fail++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
